// ### hdl/iofs_pkg.sv
// package of the inverter io function select block: register map, field
// layouts, reset values, codes and the record types that carry them.
// assumes a 10 MHz system clock and a one-word-per-register plain port.
package iofs_pkg;

   // ----------------------------------------------------------------
   // register map, byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] IOFS_COMM_CFG = 8'h00;
   localparam logic [7:0] IOFS_CARD_CFG = 8'h04;
   localparam logic [7:0] IOFS_COMB_CFG = 8'h08;
   localparam logic [7:0] IOFS_AIN_CFG = 8'h0c;
   localparam logic [7:0] IOFS_MON_CFG = 8'h10;
   localparam logic [7:0] IOFS_STATUS = 8'h14;
   localparam logic [7:0] IOFS_MASK = 8'h18;
   localparam logic [7:0] IOFS_STATE = 8'h1c;
   localparam logic [7:0] IOFS_CMD = 8'h20;
   localparam logic [7:0] IOFS_TERM_CFG = 8'h24;

   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic [15:0] IOFS_PERIOD_RST = 16'h0000;
   localparam logic [7:0] IOFS_GAIN_RST = 8'h64;
   localparam logic [9:0] IOFS_OFFSET_RST = 10'h000;
   localparam logic [9:0] IOFS_LEVEL_MAX = 10'h3ff;
   localparam logic [17:0] IOFS_GAIN_UNITY = 18'h00064;
   localparam logic [7:0] IOFS_ERR_CODE = 8'h3c;
   localparam logic [3:0] IOFS_FUNC_LOG = 4'h9;
   localparam int IOFS_N_FUNC = 9;
   localparam int IOFS_N_TERM = 5;
   // monitor level: 10-bit code, 0 to 10 v full scale
   localparam int IOFS_TICK_US = 1000;
   localparam int IOFS_CLK_MHZ = 10;
   localparam int IOFS_TICK_CYC = IOFS_TICK_US * IOFS_CLK_MHZ;

   typedef enum logic [1:0] {
      IOFS_OP_AND = 2'h0,
      IOFS_OP_OR = 2'h1,
      IOFS_OP_XOR = 2'h2
   } iofs_op_e;

   typedef enum logic [1:0] {
      IOFS_AIN_VI = 2'h0,
      IOFS_AIN_SUM = 2'h1,
      IOFS_AIN_VPOT = 2'h2,
      IOFS_AIN_IPOT = 2'h3
   } iofs_ain_e;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } iofs_bus_s;

   typedef struct packed {
      logic [9:0] voltage;
      logic [9:0] current;
      logic [9:0] pot;
      logic choice;
   } iofs_ain_s;

   typedef struct packed {
      logic [15:0] comm_period;
      logic [1:0] err_resp;
      logic [15:0] card_period;
      logic card_fitted;
      logic [3:0] op_a_sel;
      logic [3:0] op_b_sel;
      logic [1:0] op_sel;
      logic [1:0] ain_cfg;
      logic choice_used;
      logic mon_qty;
      logic [7:0] gain;
      logic [9:0] offset;
      logic [19:0] term_cfg;
      logic [2:0] status;
      logic [2:0] mask;
      logic [31:0] rdata;
      logic [15:0] tick_cnt;
      logic [15:0] wd_cnt;
      logic [15:0] card_cnt;
      logic net_timeout;
      logic card_ok;
      logic trip;
      logic [7:0] err_code;
      logic log_out;
      logic [4:0] term;
      logic [10:0] freq_cmd;
      logic [9:0] mon_level;
      logic irq;
      logic stop_req;
      logic coast_req;
   } iofs_state_s;

endpackage

// ### hdl/iofs_top.sv
// inverter io function select: network watchdogs, boolean combiner,
// output terminal mapping, analog command source and analog monitor.
// assumes strobes and inputs synchronous to i_clk, one strobe per cycle.
//
// Contract
// R1: watchdog on network activity raises timeout flag past programmed period.
// R2: on timeout, trip with error 60 or not, and stop or coast, per setting.
// R3: combiner operands A and B each pick one of nine status functions.
// R4: operator code 0 is AND, 1 is OR, 2 is XOR.
// R5: terminal assigned function 9 follows the combiner result.
// R6: fitted option card gets its own watchdog; status shown on an output.
// R7: with choice configured, voltage when choice off, current when on.
// R8: with no choice input configured, command is voltage plus current.
// R9: input configuration codes 0 to 3 map sources as the table gives.
// R10: operator must pick analog input as frequency source to use the command.
// R11: monitor quantity 0 shows output frequency, 1 shows output current.
// R12: monitor is unipolar, showing magnitude regardless of rotation direction.
// R13: monitor gain 0 to 255, default 100, scales full-scale level.
// R14: monitor offset 0 to 10 v, default 0, added to the level.
// R15: operator calibrates offset at stop, then gain at full speed.
// R16: activity restarts watchdog; flag clears on activity unless trip latched.
`timescale 1ns/100ps
module iofs_top import iofs_pkg::*; #(
   parameter int TICK_CYC = IOFS_TICK_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire iofs_bus_s i_bus,
   output logic [31:0] o_rdata,
   output logic o_irq,
   input wire logic i_comm_activity,
   input wire logic i_card_activity,
   input wire logic [IOFS_N_FUNC-1:0] i_status_func,
   input wire iofs_ain_s i_ain,
   input wire logic [10:0] i_out_freq,
   input wire logic [9:0] i_out_current,
   output logic o_net_timeout,
   output logic o_card_net_ok,
   output logic o_trip,
   output logic [7:0] o_error_code,
   output logic o_stop_req,
   output logic o_coast_req,
   output logic o_log_out,
   output logic [IOFS_N_TERM-1:0] o_term,
   output logic [10:0] o_freq_cmd,
   output logic [9:0] o_mon_level
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   iofs_state_s s;
   iofs_state_s next_s;
   logic [IOFS_N_TERM-1:0] term_val;
   logic [15:0] func_pad;
   logic log_val;

   assign func_pad = {{(16-IOFS_N_FUNC){1'b0}}, i_status_func};

   // ----------------------------------------------------------------
   // boolean combiner and terminal mapping
   // ----------------------------------------------------------------
   always_comb begin
      logic op_a;
      logic op_b;
      op_a = func_pad[s.op_a_sel]; // R3
      op_b = func_pad[s.op_b_sel]; // R3
      case (s.op_sel)
         IOFS_OP_OR: log_val = op_a | op_b; // R4
         IOFS_OP_XOR: log_val = op_a ^ op_b; // R4
         default: log_val = op_a & op_b; // R4
      endcase
   end

   // codes above the nine functions other than the logic code drive off
   generate
      for (genvar t = 0; t < IOFS_N_TERM; t++) begin : g_term
         always_comb begin
            logic [3:0] code;
            code = s.term_cfg[4*t +: 4];
            if (code == IOFS_FUNC_LOG) begin
               term_val[t] = log_val; // R5
            end else begin
               term_val[t] = func_pad[code];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic tick;
      logic timeout_now;
      logic card_lost;
      logic trip_clr;
      logic [2:0] events;
      logic [9:0] mag;
      logic [17:0] scaled;
      logic [10:0] level;
      logic [31:0] rd;
      tick = (s.tick_cnt == 16'(TICK_CYC - 1));
      timeout_now = 1'b0;
      card_lost = 1'b0;
      trip_clr = 1'b0;
      events = 3'h0;
      mag = 10'h000;
      scaled = 18'h00000;
      level = 11'h000;
      rd = 32'h0000_0000;
      next_s = s;

      // register writes
      if (i_bus.wr) begin
         case (i_bus.addr)
            IOFS_COMM_CFG: begin
               next_s.comm_period = i_bus.wdata[15:0];
               next_s.err_resp = i_bus.wdata[17:16];
            end
            IOFS_CARD_CFG: begin
               next_s.card_period = i_bus.wdata[15:0];
               next_s.card_fitted = i_bus.wdata[16];
            end
            IOFS_COMB_CFG: begin
               next_s.op_a_sel = i_bus.wdata[3:0];
               next_s.op_b_sel = i_bus.wdata[7:4];
               next_s.op_sel = i_bus.wdata[9:8];
            end
            IOFS_AIN_CFG: begin
               next_s.ain_cfg = i_bus.wdata[1:0];
               next_s.choice_used = i_bus.wdata[2];
            end
            IOFS_MON_CFG: begin
               next_s.mon_qty = i_bus.wdata[0];
               next_s.gain = i_bus.wdata[15:8];
               next_s.offset = i_bus.wdata[25:16];
            end
            IOFS_MASK: next_s.mask = i_bus.wdata[2:0];
            IOFS_CMD: trip_clr = i_bus.wdata[0];
            IOFS_TERM_CFG: next_s.term_cfg = i_bus.wdata[19:0];
            default: ;
         endcase
      end

      // millisecond time base for both watchdogs
      next_s.tick_cnt = tick ? 16'h0000 : s.tick_cnt + 16'h0001;

      // comm watchdog; a zero period leaves it disarmed
      if (i_comm_activity) begin
         next_s.wd_cnt = 16'h0000; // R16
      end else if (tick && s.wd_cnt != 16'hffff) begin
         next_s.wd_cnt = s.wd_cnt + 16'h0001;
      end
      timeout_now = (s.comm_period != IOFS_PERIOD_RST) && !i_comm_activity
         && (s.wd_cnt > s.comm_period); // R1
      if (timeout_now && !s.net_timeout) begin
         events[0] = 1'b1;
         next_s.trip = s.trip | ~s.err_resp[1]; // R2
         events[2] = ~s.err_resp[1] & ~s.trip;
      end
      if (timeout_now) begin
         next_s.net_timeout = 1'b1; // R1
      end else if (i_comm_activity && !next_s.trip) begin
         next_s.net_timeout = 1'b0; // R16
      end
      // a clear that meets a new trip loses
      if (trip_clr && !(timeout_now && !s.net_timeout && !s.err_resp[1])) begin
         next_s.trip = 1'b0;
         if (!timeout_now) begin
            next_s.net_timeout = 1'b0;
         end
      end
      next_s.stop_req = next_s.net_timeout & s.err_resp[0]; // R2
      next_s.coast_req = next_s.net_timeout & ~s.err_resp[0]; // R2
      next_s.err_code = next_s.trip ? IOFS_ERR_CODE : 8'h00; // R2

      // option card watchdog
      if (i_card_activity) begin
         next_s.card_cnt = 16'h0000;
      end else if (tick && s.card_cnt != 16'hffff) begin
         next_s.card_cnt = s.card_cnt + 16'h0001;
      end
      next_s.card_ok = s.card_fitted && (i_card_activity
         || s.card_cnt <= s.card_period); // R6
      card_lost = s.card_ok && !next_s.card_ok;
      events[1] = card_lost;

      // combiner and terminals
      next_s.log_out = log_val; // R5
      next_s.term = term_val;

      // analog command source
      if (!s.choice_used) begin
         next_s.freq_cmd = {1'b0, i_ain.voltage} + {1'b0, i_ain.current}; // R8
      end else begin
         case (s.ain_cfg)
            IOFS_AIN_VI: next_s.freq_cmd = {1'b0, i_ain.choice ? i_ain.current
               : i_ain.voltage}; // R7 R9
            IOFS_AIN_SUM: next_s.freq_cmd = {1'b0, i_ain.voltage}
               + {1'b0, i_ain.current}; // R9
            IOFS_AIN_VPOT: next_s.freq_cmd = {1'b0, i_ain.choice ? i_ain.pot
               : i_ain.voltage}; // R9
            default: next_s.freq_cmd = {1'b0, i_ain.choice ? i_ain.pot
               : i_ain.current}; // R9
         endcase
      end

      // analog monitor: magnitude, gain per hundred, offset, clipped
      if (s.mon_qty) begin
         mag = i_out_current; // R11
      end else begin
         mag = i_out_freq[10] ? 10'(-i_out_freq) : i_out_freq[9:0]; // R11 R12
      end
      scaled = (18'(mag) * 18'(s.gain)) / IOFS_GAIN_UNITY; // R13
      level = 11'(scaled[10:0]) + {1'b0, s.offset}; // R14
      if (scaled > 18'(IOFS_LEVEL_MAX) || level > {1'b0, IOFS_LEVEL_MAX}) begin
         next_s.mon_level = IOFS_LEVEL_MAX; // R12
      end else begin
         next_s.mon_level = level[9:0];
      end

      // reads; status clears on read but a new event still lands
      case (i_bus.addr)
         IOFS_COMM_CFG: rd = {14'h0000, s.err_resp, s.comm_period};
         IOFS_CARD_CFG: rd = {15'h0000, s.card_fitted, s.card_period};
         IOFS_COMB_CFG: rd = {22'h000000, s.op_sel, s.op_b_sel, s.op_a_sel};
         IOFS_AIN_CFG: rd = {29'h00000000, s.choice_used, s.ain_cfg};
         IOFS_MON_CFG: rd = {6'h00, s.offset, s.gain, 7'h00, s.mon_qty};
         IOFS_STATUS: rd = {29'h00000000, s.status};
         IOFS_MASK: rd = {29'h00000000, s.mask};
         IOFS_STATE: rd = {5'h00, s.freq_cmd, s.mon_level, 2'h0, s.log_out,
            s.trip, s.card_ok, s.net_timeout};
         IOFS_TERM_CFG: rd = {12'h000, s.term_cfg};
         default: rd = 32'h0000_0000;
      endcase
      next_s.rdata = i_bus.rd ? rd : 32'h0000_0000;
      if (i_bus.rd && i_bus.addr == IOFS_STATUS) begin
         next_s.status = events;
      end else begin
         next_s.status = s.status | events;
      end
      next_s.irq = |(next_s.status & next_s.mask);
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s <= '0;
         s.gain <= IOFS_GAIN_RST;
         s.offset <= IOFS_OFFSET_RST;
      end else begin
         s <= next_s;
      end
   end

   assign o_rdata = s.rdata;
   assign o_irq = s.irq;
   assign o_net_timeout = s.net_timeout;
   assign o_card_net_ok = s.card_ok;
   assign o_trip = s.trip;
   assign o_error_code = s.err_code;
   assign o_stop_req = s.stop_req;
   assign o_coast_req = s.coast_req;
   assign o_log_out = s.log_out;
   assign o_term = s.term;
   assign o_freq_cmd = s.freq_cmd;
   assign o_mon_level = s.mon_level;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   timeout_set_a: assert property (@(posedge i_clk) disable iff (i_rst) // R1
      (s.comm_period != 16'h0000 && !i_comm_activity && s.wd_cnt > s.comm_period)
      |=> o_net_timeout)
      else $error("timeout flag not raised after period");

   trip_code_a: assert property (@(posedge i_clk) disable iff (i_rst) // R2
      $rose(o_net_timeout) && !$past(s.err_resp[1]) |-> o_trip && o_error_code == 8'h3c)
      else $error("timeout with trip response did not trip");

   no_trip_a: assert property (@(posedge i_clk) disable iff (i_rst) // R2
      $rose(o_net_timeout) && $past(s.err_resp[1]) && !$past(s.trip) |-> !o_trip)
      else $error("timeout without trip response tripped");

   timeout_clear_a: assert property (@(posedge i_clk) disable iff (i_rst) // R16
      i_comm_activity && !s.trip && !i_bus.wr ##1 !o_trip |-> !o_net_timeout)
      else $error("timeout flag held after activity");

   logic_or_a: assert property (@(posedge i_clk) disable iff (i_rst) // R4
      s.op_sel == 2'h1 && !i_bus.wr |=> o_log_out ==
      ($past(func_pad[s.op_a_sel]) | $past(func_pad[s.op_b_sel])))
      else $error("combiner or result wrong");

   term_log_a: assert property (@(posedge i_clk) disable iff (i_rst) // R5
      s.term_cfg[3:0] == 4'h9 && !i_bus.wr |=> o_term[0] == o_log_out)
      else $error("logic terminal differs from combiner");

   card_ok_a: assert property (@(posedge i_clk) disable iff (i_rst) // R6
      !s.card_fitted |=> !o_card_net_ok)
      else $error("card status set with no card");

   sum_cmd_a: assert property (@(posedge i_clk) disable iff (i_rst) // R8
      !s.choice_used |=> o_freq_cmd == $past({1'b0, i_ain.voltage}) + $past({1'b0, i_ain.current}))
      else $error("command is not the input sum");

   pot_cmd_a: assert property (@(posedge i_clk) disable iff (i_rst) // R9
      s.choice_used && s.ain_cfg == 2'h3 && i_ain.choice |=> o_freq_cmd == {1'b0, $past(i_ain.pot)})
      else $error("keypad pot not selected");

   mon_offset_a: assert property (@(posedge i_clk) disable iff (i_rst) // R14
      s.mon_qty && i_out_current == 10'h000 |=> o_mon_level == $past(s.offset))
      else $error("monitor at zero differs from offset");

   and_logic_a: assert property (@(posedge i_clk) disable iff (i_rst) // R4
      s.op_sel == 2'h0 |=> o_log_out ==
      ($past(func_pad[s.op_a_sel]) & $past(func_pad[s.op_b_sel])))
      else $error("combiner and result wrong");

   xor_logic_a: assert property (@(posedge i_clk) disable iff (i_rst) // R4
      s.op_sel == 2'h2 |=> o_log_out ==
      ($past(func_pad[s.op_a_sel]) ^ $past(func_pad[s.op_b_sel])))
      else $error("combiner xor result wrong");

   volt_cmd_a: assert property (@(posedge i_clk) disable iff (i_rst) // R7
      s.choice_used && s.ain_cfg == 2'h0 |=> o_freq_cmd ==
      {1'b0, $past(i_ain.choice) ? $past(i_ain.current) : $past(i_ain.voltage)})
      else $error("choice input did not pick voltage or current");

   mon_freq_a: assert property (@(posedge i_clk) disable iff (i_rst) // R11
      !s.mon_qty && s.gain == 8'h64 && s.offset == 10'h000 && !i_out_freq[10]
      |=> o_mon_level == $past(i_out_freq[9:0]))
      else $error("monitor does not follow frequency");

   mon_reverse_a: assert property (@(posedge i_clk) disable iff (i_rst) // R12
      !s.mon_qty && s.gain == 8'h64 && s.offset == 10'h000 && i_out_freq[10]
      |=> o_mon_level == $past(~i_out_freq[9:0]) + 10'h001)
      else $error("monitor not magnitude in reverse");

   gain_zero_a: assert property (@(posedge i_clk) disable iff (i_rst) // R13
      s.gain == 8'h00 |=> o_mon_level == $past(s.offset))
      else $error("zero gain leaves more than offset");

   stop_coast_a: assert property (@(posedge i_clk) disable iff (i_rst) // R2
      (o_stop_req | o_coast_req) == o_net_timeout && !(o_stop_req && o_coast_req))
      else $error("stop or coast request out of step with timeout");

   card_loss_a: assert property (@(posedge i_clk) disable iff (i_rst) // R6
      s.card_fitted && !i_card_activity && s.card_cnt > s.card_period |=> !o_card_net_ok)
      else $error("card status held after card watchdog expired");

endmodule

// ### test/iofs_host_model.sv
// partner model: network host feeding the block's activity input.
// assumes one clock shared with the block; i_quiet silences the host.
`timescale 1ns/100ps
module iofs_host_model #(
   parameter int GAP = 5
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_quiet,
   output logic o_activity
);
   int cnt;
   // ---------------------------------------------------------------
   // traffic
   // ---------------------------------------------------------------
   // gap stays below one watchdog tick so a live host never times out;
   // a silent host holds the line low, it does not repeat its last pulse
   always_ff @(posedge i_clk) begin
      if (i_rst || i_quiet) begin
         cnt <= 0;
         o_activity <= 1'b0;
      end else begin
         cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
         o_activity <= (cnt == GAP - 1);
      end
   end
endmodule

// ### test/test_iofs_top.sv
// testbench of the io function select block: register port, combiner,
// analog source, monitor scaling and both network watchdogs.
// assumes the block is built with a 10-cycle watchdog tick.
`timescale 1ns/100ps
module test_iofs_top import iofs_pkg::*;;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   iofs_bus_s i_bus = '0;
   logic [8:0] i_status_func = '0;
   iofs_ain_s i_ain = '0;
   logic [10:0] i_out_freq = '0;
   logic [9:0] i_out_current = '0;
   logic quiet_comm = 1'b0;
   logic quiet_card = 1'b0;
   logic act_comm, act_card, o_irq, o_net_timeout, o_card_net_ok, o_trip;
   logic o_stop_req, o_coast_req, o_log_out;
   logic [31:0] o_rdata;
   logic [7:0] o_error_code;
   logic [4:0] o_term;
   logic [10:0] o_freq_cmd;
   logic [9:0] o_mon_level;
   int miscompares = 0;
   int checks = 0;

   always #50 i_clk = ~i_clk;

   iofs_top #(.TICK_CYC(10)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus),
      .o_rdata(o_rdata), .o_irq(o_irq), .i_comm_activity(act_comm),
      .i_card_activity(act_card), .i_status_func(i_status_func), .i_ain(i_ain),
      .i_out_freq(i_out_freq), .i_out_current(i_out_current),
      .o_net_timeout(o_net_timeout), .o_card_net_ok(o_card_net_ok), .o_trip(o_trip),
      .o_error_code(o_error_code), .o_stop_req(o_stop_req), .o_coast_req(o_coast_req),
      .o_log_out(o_log_out), .o_term(o_term), .o_freq_cmd(o_freq_cmd),
      .o_mon_level(o_mon_level));
   iofs_host_model comm_u (.i_clk(i_clk), .i_rst(i_rst), .i_quiet(quiet_comm),
      .o_activity(act_comm));
   iofs_host_model card_u (.i_clk(i_clk), .i_rst(i_rst), .i_quiet(quiet_card),
      .o_activity(act_card));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic look(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_clk);
      i_bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
      @(posedge i_clk);
      i_bus.rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      logic [31:0] d;
      rd(IOFS_MON_CFG, d);
      chk(d, 32'h00006400, "monitor defaults");
      rd(8'h30, d);
      chk(d, 32'h0, "unmapped read");
      wr(IOFS_STATE, 32'hffffffff);
      rd(IOFS_STATE, d);
      chk(d, 32'h0, "state after write");
      $display("test regs done");
   endtask

   task automatic t_comb;
      logic a, b, e;
      wr(IOFS_TERM_CFG, 32'h00000009);
      for (int op = 0; op < 4; op++) begin
         for (int ab = 0; ab < 4; ab++) begin
            a = ab[0];
            b = ab[1];
            e = (op == 1) ? (a | b) : (op == 2) ? (a ^ b) : (a & b);
            wr(IOFS_COMB_CFG, {22'h0, op[1:0], 8'h10});
            @(posedge i_clk);
            i_status_func <= {7'h0, b, a};
            look(3);
            chk(o_log_out, e, "combiner");
            chk(o_term, {{4{a}}, e}, "terminals");
         end
      end
      $display("test comb done");
   endtask

   function automatic logic [10:0] src(input int c, input logic ch);
      case (c)
         1: return 11'h1a0;
         2: return ch ? 11'h3ff : 11'h100;
         3: return ch ? 11'h3ff : 11'h0a0;
         default: return ch ? 11'h0a0 : 11'h100;
      endcase
   endfunction

   task automatic t_ain;
      for (int c = 0; c < 4; c++) begin
         for (int ch = 0; ch < 2; ch++) begin
            wr(IOFS_AIN_CFG, {29'h0, 1'b1, c[1:0]});
            @(posedge i_clk);
            i_ain <= '{voltage: 10'h100, current: 10'h0a0, pot: 10'h3ff, choice: ch[0]};
            look(3);
            chk(o_freq_cmd, src(c, ch[0]), "command source");
         end
      end
      wr(IOFS_AIN_CFG, 32'h0);
      look(3);
      chk(o_freq_cmd, 11'h1a0, "sum with no choice input");
      $display("test ain done");
   endtask

   task automatic mon(input logic q, input logic [7:0] g, input logic [9:0] off,
                      input logic [10:0] f, input logic [9:0] c, input logic [9:0] e);
      wr(IOFS_MON_CFG, {6'h0, off, g, 7'h0, q});
      @(posedge i_clk);
      i_out_freq <= f;
      i_out_current <= c;
      look(3);
      chk(o_mon_level, e, "monitor level");
   endtask

   task automatic t_mon;
      mon(1'b0, 8'h64, 10'h0, 11'h6d4, 10'h0, 10'h12c);
      mon(1'b0, 8'h64, 10'h0, 11'h12c, 10'h0, 10'h12c);
      mon(1'b1, 8'h32, 10'h00a, 11'h12c, 10'h190, 10'h0d2);
      mon(1'b1, 8'hff, 10'h3ff, 11'h0, 10'h3e8, 10'h3ff);
      mon(1'b0, 8'h00, 10'h020, 11'h12c, 10'h0, 10'h020);
      // calibration order: offset with the motor stopped, then gain at full speed
      mon(1'b0, 8'h64, 10'h010, 11'h000, 10'h0, 10'h010);
      mon(1'b0, 8'h5a, 10'h010, 11'h3e8, 10'h0, 10'h394);
      $display("test mon done");
   endtask

   task automatic t_wd;
      int n;
      logic [31:0] d;
      wr(IOFS_MASK, 32'h7);
      wr(IOFS_COMM_CFG, 32'h00010001);
      @(posedge i_clk);
      quiet_comm <= 1'b1;
      for (n = 0; n < 300 && o_net_timeout !== 1'b1; n++) look(1);
      chk(n >= 10 && n <= 40, 1'b1, "timeout delay");
      look(2);
      chk({o_trip, o_stop_req, o_coast_req, o_irq}, 4'b1101, "trip response");
      chk(o_error_code, 8'h3c, "error code");
      rd(IOFS_STATUS, d);
      chk(d & 32'h5, 32'h5, "status events");
      look(1);
      chk(o_irq, 1'b0, "irq after read clear");
      @(posedge i_clk);
      quiet_comm <= 1'b0;
      look(30);
      chk(o_net_timeout, 1'b1, "flag held by trip");
      wr(IOFS_CMD, 32'h1);
      look(3);
      chk({o_net_timeout, o_trip, o_error_code}, 10'h0, "trip cleared");
      wr(IOFS_COMM_CFG, 32'h00020001);
      @(posedge i_clk);
      quiet_comm <= 1'b1;
      for (n = 0; n < 300 && o_net_timeout !== 1'b1; n++) look(1);
      look(2);
      chk({o_net_timeout, o_trip, o_stop_req, o_coast_req}, 4'b1001, "coast");
      @(posedge i_clk);
      quiet_comm <= 1'b0;
      look(20);
      chk({o_net_timeout, o_coast_req}, 2'b00, "flag clears on activity");
      $display("test wd done");
   endtask

   task automatic t_card;
      int n;
      logic [31:0] d;
      wr(IOFS_CARD_CFG, 32'h00010001);
      look(20);
      chk(o_card_net_ok, 1'b1, "card ok");
      @(posedge i_clk);
      quiet_card <= 1'b1;
      for (n = 0; n < 300 && o_card_net_ok !== 1'b0; n++) look(1);
      chk(n >= 10 && n <= 40, 1'b1, "card loss delay");
      rd(IOFS_STATUS, d);
      chk(d[1], 1'b1, "card loss event");
      @(posedge i_clk);
      quiet_card <= 1'b0;
      look(10);
      chk(o_card_net_ok, 1'b1, "card back");
      $display("test card done");
   endtask

   // ---------------------------------------------------------------
   // run
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      t_regs();
      t_comb();
      // stimulus stands for a host that picked the analog input as source
      t_ain();
      t_mon();
      t_wd();
      t_card();
      tally_and_finish();
   end

   // the whole run is well under 2000 cycles; a hang stops here
   initial begin
      #(100 * 20000);
      miscompares++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule
